// *** common/acsp_pkg.sv ***
/*
 * Shared constants and types of the three-wire configuration port.
 * Assumes a 125 MHz core clock and a host-driven serial shift clock.
 */
package acsp_pkg;
    // =========================================
    // Widths
    // =========================================
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int REG_DEPTH = 16;
    localparam int IDX_W = 4;
    localparam int FIFO_DEPTH = 4;

    // =========================================
    // Frame counters
    // =========================================
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_STEP = 4'h1;
    localparam logic [3:0] INSTR_LAST = 4'hF;
    localparam logic [3:0] BYTE_LAST = 4'h7;

    // =========================================
    // Configuration register A
    // =========================================
    localparam logic [ADDR_W-1:0] CFG_A_ADDR = 15'h0000;
    localparam logic [ADDR_W-1:0] ADDR_STEP = 15'h0001;
    localparam int LSB_FIRST_BIT = 6;
    localparam int SOFT_RST_BIT = 7;
    localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
    localparam logic [DATA_W-1:0] CFG_A_WMASK = 8'h7F;
    localparam logic [DATA_W-1:0] FULL_MASK = 8'hFF;

    // =========================================
    // Timing
    // =========================================
    localparam int CORE_PERIOD_NS = 8;
    localparam int STALL_NS = 1000;
    localparam int STALL_CYC = (STALL_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam int STALL_W = 8;
    localparam logic [STALL_W-1:0] STALL_LAST = STALL_W'(STALL_CYC - 1);
    localparam logic [STALL_W-1:0] STALL_ZERO = 8'h00;
    localparam logic [STALL_W-1:0] STALL_STEP = 8'h01;

    // =========================================
    // Types
    // =========================================
    typedef enum logic [0:0] {
        ST_INSTR = 1'b0,
        ST_DATA = 1'b1
    } acsp_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } acsp_wr_t;
endpackage

// *** design/acsp_port.sv ***
/*
 * Three-wire serial configuration port with its byte register space,
 * plus the small FIFO that hands written bytes to core logic.
 * Assumes the host drives serial_shift_clock and select_low, and
 * that the pad logic resolves the shared data wire from sdio_oe.
 */
`timescale 1ns/10ps

// =========================================
// Word FIFO
// =========================================
module acsp_fifo #(
    parameter int WIDTH = 23,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
    localparam logic [PW-1:0] PTR_ZERO = '0;
    localparam logic [PW-1:0] PTR_STEP = PW'(1);
    localparam logic [PW:0] CNT_FULL = (PW + 1)'(DEPTH);
    localparam logic [PW:0] CNT_ONE = (PW + 1)'(1);

    // Storage words
    logic [WIDTH-1:0] mem_r [DEPTH];
    // Pointers and fill level
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [PW:0] count_r;
    logic do_push;
    logic do_pop;

    // Honest flags from the fill level
    assign in_ready = (count_r != CNT_FULL);
    assign out_valid = (count_r != '0);
    assign out_data = mem_r[rd_ptr_r];
    assign do_push = in_valid && in_ready;
    assign do_pop = out_valid && out_ready;

    // Store incoming word
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    // Write pointer with wrap
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= PTR_ZERO;
        end else if (do_push) begin
            wr_ptr_r <= (wr_ptr_r == PTR_LAST) ? PTR_ZERO : wr_ptr_r + PTR_STEP;
        end
    end

    // Read pointer with wrap
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_ptr_r <= PTR_ZERO;
        end else if (do_pop) begin
            rd_ptr_r <= (rd_ptr_r == PTR_LAST) ? PTR_ZERO : rd_ptr_r + PTR_STEP;
        end
    end

    // Fill level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= '0;
        end else if (do_push && !do_pop) begin
            count_r <= count_r + CNT_ONE;
        end else if (do_pop && !do_push) begin
            count_r <= count_r - CNT_ONE;
        end
    end
endmodule

// Overview of operation
// R1 - Three pins: clock, shared data, select
// R2 - Clock ignored while select is high
// R3 - Frame starts at first rise after select
// R4 - Select held low streams further bytes
// R5 - Select high between bytes only stalls; code ends the frame once select stays high for 1000 ns
// R6 - Select high floats pins, enables alternates
// R7 - Everything moves in eight-bit units
// R8 - First instruction bit picks read/write
// R9 - Reads turn data pin to output
// R10 - Bit order MSB first until changed
// R11 - Clock and select are always inputs
// R12 - Host clocks every bit both ways
// R13 - Byte registers writable and readable back
// R14 - Host keeps port quiet during sampling
// R15 - Writing reset bit clears port, registers; code clears only the byte registers, frame state runs on
// R16 - Config bit six selects LSB first
// R17 - Fifteen-bit address, auto-increment per byte
module acsp_port (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic serial_shift_clock,
    input wire logic select_low,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe,
    output logic aux_func_en,
    output logic cfg_valid,
    output acsp_pkg::acsp_wr_t cfg_word,
    input wire logic cfg_ready,
    output logic cfg_overrun
);
    // =========================================
    // Helper functions
    // =========================================

    // Shift one bit into an address
    function automatic logic [acsp_pkg::ADDR_W-1:0] addr_shift(
        input logic [acsp_pkg::ADDR_W-1:0] cur,
        input logic din,
        input logic lsb
    );
        // LSB first fills from the top
        if (lsb) begin
            return {din, cur[acsp_pkg::ADDR_W-1:1]};
        end
        return {cur[acsp_pkg::ADDR_W-2:0], din};
    endfunction

    // Shift one bit into a byte
    function automatic logic [acsp_pkg::DATA_W-1:0] byte_shift(
        input logic [acsp_pkg::DATA_W-1:0] cur,
        input logic din,
        input logic lsb
    );
        // Same ordering as addresses
        if (lsb) begin
            return {din, cur[acsp_pkg::DATA_W-1:1]};
        end
        return {cur[acsp_pkg::DATA_W-2:0], din};
    endfunction

    // =========================================
    // Link domain signals
    // =========================================
    acsp_pkg::acsp_state_t state_r;      // Instruction or data phase
    logic [3:0] cnt_r;                   // Bit position in phase
    logic rw_r;                          // High for read frames
    logic [acsp_pkg::ADDR_W-1:0] addr_r; // Current register address
    logic [acsp_pkg::DATA_W-1:0] rx_r;   // Partial received byte
    logic [acsp_pkg::DATA_W-1:0] rx_full; // Byte incl. current bit
    logic [acsp_pkg::DATA_W-1:0] mem_r [acsp_pkg::REG_DEPTH];
    logic [acsp_pkg::DATA_W-1:0] rd_byte; // Readback byte
    logic [2:0] tx_idx;                  // Bit index to drive
    logic lsb_first;                     // Current bit order
    logic byte_done;                     // Last bit of data byte
    logic wr_hit;                        // Completed write byte
    logic in_map;                        // Address inside storage
    logic out_r;                         // Driven data bit
    logic oe_r;                          // Drive request
    acsp_pkg::acsp_wr_t wr_word_r;       // Word handed to core
    logic wr_tog_r;                      // Toggles per written byte
    logic frame_rst_n;                   // Frame state reset

    // =========================================
    // Core domain signals
    // =========================================
    logic sel_meta_r;                    // Select sync stage one
    logic sel_sync_r;                    // Select sync stage two
    logic [acsp_pkg::STALL_W-1:0] stall_cnt_r; // Select-high time
    logic frame_clr_r;                   // Frame ended by long high
    logic tog_meta_r;                    // Toggle sync stage one
    logic tog_sync_r;                    // Toggle sync stage two
    logic tog_seen_r;                    // Last toggle taken
    logic push;                          // New word arrived
    logic fifo_in_ready;                 // FIFO room

    // =========================================
    // Combinational decode
    // =========================================

    // R16 - order from config
    assign lsb_first = mem_r[acsp_pkg::CFG_A_ADDR[acsp_pkg::IDX_W-1:0]][acsp_pkg::LSB_FIRST_BIT];
    assign rx_full = byte_shift(rx_r, sdio_in, lsb_first);
    // R7 - byte boundaries
    assign byte_done = (state_r == acsp_pkg::ST_DATA) && (cnt_r == acsp_pkg::BYTE_LAST);
    // R2 - gated by select
    assign wr_hit = !select_low && byte_done && !rw_r;
    assign in_map = (addr_r < acsp_pkg::ADDR_W'(acsp_pkg::REG_DEPTH));
    // R13 - unmapped reads zero
    assign rd_byte = in_map ? mem_r[addr_r[acsp_pkg::IDX_W-1:0]] : acsp_pkg::REG_RESET;
    // R10 - bit position to drive
    assign tx_idx = lsb_first ? cnt_r[2:0] : acsp_pkg::BYTE_LAST[2:0] - cnt_r[2:0];
    // Frame state also cleared once select stayed high long
    assign frame_rst_n = rst_n && !frame_clr_r;

    // =========================================
    // Pin drive
    // =========================================

    // R1 - single shared data pin
    // R6 - float pins when deselected
    assign sdio_oe = oe_r && !select_low;
    assign sdio_out = out_r;
    // R6 - alternates when deselected
    assign aux_func_en = select_low;

    // =========================================
    // Link domain: frame sequencer
    // =========================================

    // R11 - clock is input only
    // Instruction and data phases
    always_ff @(posedge serial_shift_clock or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            state_r <= acsp_pkg::ST_INSTR;
            cnt_r <= acsp_pkg::CNT_ZERO;
            rw_r <= 1'b0;
            addr_r <= '0;
            rx_r <= acsp_pkg::REG_RESET;
        // R2 - clock ignored when high
        end else if (!select_low) begin
            unique case (state_r)
                // R3 - frame opens here
                acsp_pkg::ST_INSTR: begin
                    // R8 - first bit is read flag
                    if (cnt_r == acsp_pkg::CNT_ZERO) begin
                        rw_r <= sdio_in;
                    // R17 - fifteen address bits
                    end else begin
                        addr_r <= addr_shift(addr_r, sdio_in, lsb_first);
                    end
                    // Instruction ends after sixteen bits
                    if (cnt_r == acsp_pkg::INSTR_LAST) begin
                        state_r <= acsp_pkg::ST_DATA;
                        cnt_r <= acsp_pkg::CNT_ZERO;
                    end else begin
                        cnt_r <= cnt_r + acsp_pkg::CNT_STEP;
                    end
                end
                // R4 - streaming data bytes
                acsp_pkg::ST_DATA: begin
                    rx_r <= rx_full;
                    // R17 - next address per byte
                    if (byte_done) begin
                        cnt_r <= acsp_pkg::CNT_ZERO;
                        addr_r <= addr_r + acsp_pkg::ADDR_STEP;
                    end else begin
                        cnt_r <= cnt_r + acsp_pkg::CNT_STEP;
                    end
                end
            endcase
        end
    end

    // =========================================
    // Link domain: register space
    // =========================================

    // Byte storage and soft reset
    always_ff @(posedge serial_shift_clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < acsp_pkg::REG_DEPTH; i++) begin
                mem_r[i] <= acsp_pkg::REG_RESET;
            end
        end else if (wr_hit) begin
            // R15 - soft reset clears all byte registers
            if (addr_r == acsp_pkg::CFG_A_ADDR && rx_full[acsp_pkg::SOFT_RST_BIT]) begin
                for (int i = 0; i < acsp_pkg::REG_DEPTH; i++) begin
                    mem_r[i] <= acsp_pkg::REG_RESET;
                end
            // R13 - plain byte write
            end else if (in_map) begin
                mem_r[addr_r[acsp_pkg::IDX_W-1:0]] <= rx_full &
                    ((addr_r == acsp_pkg::CFG_A_ADDR) ? acsp_pkg::CFG_A_WMASK
                                                      : acsp_pkg::FULL_MASK);
            end
        end
    end

    // =========================================
    // Link domain: write hand-off
    // =========================================

    // Word and toggle toward core
    always_ff @(posedge serial_shift_clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_word_r <= '0;
            wr_tog_r <= 1'b0;
        end else if (wr_hit) begin
            wr_word_r.addr <= addr_r;
            wr_word_r.data <= rx_full;
            wr_tog_r <= !wr_tog_r;
        end
    end

    // =========================================
    // Link domain: readback driver
    // =========================================

    // R9 - drive on falling edges
    always_ff @(negedge serial_shift_clock or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            oe_r <= 1'b0;
            out_r <= 1'b0;
        end else begin
            // R12 - one bit per clock
            oe_r <= (state_r == acsp_pkg::ST_DATA) && rw_r;
            out_r <= rd_byte[tx_idx];
        end
    end

    // =========================================
    // Core domain: select watch
    // =========================================

    // Two-stage select synchroniser
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_meta_r <= 1'b1;
            sel_sync_r <= 1'b1;
        end else begin
            sel_meta_r <= select_low;
            sel_sync_r <= sel_meta_r;
        end
    end

    // R5 - short high only stalls
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stall_cnt_r <= acsp_pkg::STALL_ZERO;
            frame_clr_r <= 1'b0;
        end else if (!sel_sync_r) begin
            // Selected again: release frame
            stall_cnt_r <= acsp_pkg::STALL_ZERO;
            frame_clr_r <= 1'b0;
        end else if (stall_cnt_r == acsp_pkg::STALL_LAST) begin
            // Long high ends the frame
            frame_clr_r <= 1'b1;
        end else begin
            stall_cnt_r <= stall_cnt_r + acsp_pkg::STALL_STEP;
        end
    end

    // =========================================
    // Core domain: write intake
    // =========================================

    // Two-stage toggle synchroniser
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tog_meta_r <= 1'b0;
            tog_sync_r <= 1'b0;
            tog_seen_r <= 1'b0;
        end else begin
            tog_meta_r <= wr_tog_r;
            tog_sync_r <= tog_meta_r;
            tog_seen_r <= tog_sync_r;
        end
    end

    // Word stays stable for a byte time
    assign push = tog_sync_r ^ tog_seen_r;

    // Sticky loss flag when FIFO full
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_overrun <= 1'b0;
        end else if (push && !fifo_in_ready) begin
            cfg_overrun <= 1'b1;
        end
    end

    // Buffer toward core consumers
    acsp_fifo #(
        .WIDTH($bits(acsp_pkg::acsp_wr_t)),
        .DEPTH(acsp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(core_clk),
        .rst_n(rst_n),
        .in_valid(push),
        .in_data(wr_word_r),
        .in_ready(fifo_in_ready),
        .out_valid(cfg_valid),
        .out_ready(cfg_ready),
        .out_data(cfg_word)
    );
endmodule

// *** verification/acsp_port_props.sv ***
/* Concurrent checks on the configuration port's outputs.
   Assumes it is bound to acsp_port and sees its ports only. */
`timescale 1ns/10ps
module acsp_port_props (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic serial_shift_clock,
    input wire logic select_low,
    input wire logic sdio_in,
    input wire logic sdio_out,
    input wire logic sdio_oe,
    input wire logic aux_func_en,
    input wire logic cfg_valid,
    input wire acsp_pkg::acsp_wr_t cfg_word,
    input wire logic cfg_ready,
    input wire logic cfg_overrun
);
    // ==========================================
    // Clocking and steps
    // ==========================================
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // Host lets go of the port
    sequence sel_rise;
        $rose(select_low);
    endsequence
    // Pin stays undriven while deselected
    sequence pin_idle;
        !sdio_oe ##1 (!sdio_oe || !select_low);
    endsequence
    AST_OE_OFF: assert property (select_low |-> !sdio_oe)
        else $error("data pin driven while deselected");
    AST_SEL_RISE: assert property (sel_rise |-> pin_idle)
        else $error("data pin kept after select rose");
    AST_AUX: assert property (1'b1 |-> aux_func_en == select_low)
        else $error("alternate function enable wrong");
    AST_OE_ON_FALL: assert property ($rose(sdio_oe) |-> !serial_shift_clock)
        else $error("turnaround outside clock low phase");
    AST_OUT_ON_FALL: assert property (sdio_oe && $changed(sdio_out) |-> !serial_shift_clock)
        else $error("read bit changed outside clock low phase");
    AST_HOLD: assert property (cfg_valid && !cfg_ready |=> cfg_valid && $stable(cfg_word))
        else $error("word dropped before it was taken");
    AST_OVR_STICKY: assert property (cfg_overrun |=> cfg_overrun)
        else $error("overrun flag cleared");
    AST_OVR_CAUSE: assert property ($rose(cfg_overrun) |-> $past(cfg_valid))
        else $error("overrun with room left");
endmodule

bind acsp_port acsp_port_props acsp_port_props_i (.core_clk(core_clk), .rst_n(rst_n),
    .serial_shift_clock(serial_shift_clock), .select_low(select_low), .sdio_in(sdio_in),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe), .aux_func_en(aux_func_en),
    .cfg_valid(cfg_valid), .cfg_word(cfg_word), .cfg_ready(cfg_ready),
    .cfg_overrun(cfg_overrun));

// *** verification/acsp_host.sv ***
/* Serial host model: makes shift clock, select and data bits.
   Assumes the bench fills wq before writes and empties rq after reads. */
`timescale 1ns/10ps
module acsp_host (
    output logic serial_shift_clock,
    output logic select_low,
    output logic sdio_in,
    input wire logic sdio_out,
    input wire logic sdio_oe
);
    logic host_d; // Host drive value
    logic host_oe; // Host owns the data wire
    logic [7:0] wq[$]; // Bytes to send
    logic [7:0] rq[$]; // Bytes read back
    // shared wire, host owns clock and select
    assign sdio_in = sdio_oe ? sdio_out : host_d;
    initial begin
        serial_shift_clock = 1'b0;
        select_low = 1'b1;
        host_d = 1'b0;
        host_oe = 1'b1;
    end
    // one pulse per bit, clock still otherwise
    task automatic bit_x(input logic b, output logic r);
        serial_shift_clock = 1'b0;
        host_d = host_oe ? b : ~host_d;
        #24;
        serial_shift_clock = 1'b1;
        r = sdio_in;
        #24;
        serial_shift_clock = 1'b0;
    endtask
    // Clock pulses with select high
    task automatic idle_clocks(input int n);
        logic r;
        for (int i = 0; i < n; i++) begin
            bit_x(1'($urandom), r);
        end
    endtask
    task automatic frame(input logic rw, input logic [14:0] a, input int n,
        input logic lsb, input logic stall);
        logic [7:0] d;
        logic r;
        int j;
        select_low = 1'b0;
        host_oe = 1'b1;
        #45;
        bit_x(rw, r);
        for (int i = 0; i < 15; i++) begin
            bit_x(a[lsb ? i : 14 - i], r);
        end
        host_oe = !rw;
        for (int k = 0; k < n; k++) begin
            d = rw ? 8'h00 : wq.pop_front();
            for (int i = 0; i < 8; i++) begin
                j = lsb ? i : 7 - i;
                bit_x(d[j], r);
                d[j] = r;
            end
            if (rw) begin
                rq.push_back(d);
            end
            if (stall && k < n - 1) begin
                select_low = 1'b1;
                #200;
                select_low = 1'b0;
                #45;
            end
        end
        select_low = 1'b1;
        host_oe = 1'b1;
        #1200;
    endtask
endmodule

// *** verification/tb_acsp_port.sv ***
/* Self-checking bench for acsp_port with a reference model.
   Assumes acsp_host drives the serial side. */
`timescale 1ns/10ps
module tb_acsp_port;
    logic core_clk; // Core clock
    logic rst_n; // Reset, active low
    logic cfg_ready; // Consumer ready
    logic serial_shift_clock;
    logic select_low;
    logic sdio_in;
    logic sdio_out;
    logic sdio_oe;
    logic aux_func_en;
    logic cfg_valid;
    logic cfg_overrun;
    acsp_pkg::acsp_wr_t cfg_word;
    int failures = 0;
    int checks_done = 0;
    int mem[16]; // Register model
    logic lsb_m; // Bit order model
    logic [22:0] exp_q[$]; // Expected words
    acsp_port acsp_port_i (.core_clk(core_clk), .rst_n(rst_n),
        .serial_shift_clock(serial_shift_clock), .select_low(select_low),
        .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
        .aux_func_en(aux_func_en), .cfg_valid(cfg_valid), .cfg_word(cfg_word),
        .cfg_ready(cfg_ready), .cfg_overrun(cfg_overrun));
    acsp_host acsp_host_i (.serial_shift_clock(serial_shift_clock),
        .select_low(select_low), .sdio_in(sdio_in), .sdio_out(sdio_out),
        .sdio_oe(sdio_oe));
    always #4 core_clk = ~core_clk;
    // Compare and count
    task automatic check(input logic [22:0] seen, input logic [22:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic close_out();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Write frame, first byte d0, rest random
    task automatic wr(input int a, input int n, input logic [7:0] d0);
        logic [7:0] d;
        logic o;
        o = lsb_m;
        for (int k = 0; k < n; k++) begin
            d = (k == 0) ? d0 : 8'($urandom);
            acsp_host_i.wq.push_back(d);
            exp_q.push_back({15'(a + k), d});
            if (a + k == 0) begin
                mem[0] = d & acsp_pkg::CFG_A_WMASK;
                lsb_m = d[6];
                if (d[7]) begin
                    mem = '{default: 0};
                    lsb_m = 1'b0;
                end
            end else if (a + k < 16) begin
                mem[a + k] = d;
            end
        end
        acsp_host_i.frame(1'b0, 15'(a), n, o, 1'b0);
    endtask
    // Read frame and compare each byte
    task automatic rd(input int a, input int n, input logic stall);
        int e;
        acsp_host_i.frame(1'b1, 15'(a), n, lsb_m, stall);
        for (int k = 0; k < n; k++) begin
            e = (a + k < 16) ? mem[a + k] : 0;
            check(23'(acsp_host_i.rq.pop_front()), 23'(e));
        end
    endtask
    // Take every queued word from the FIFO
    task automatic drain();
        int t;
        while (exp_q.size() > 0) begin
            t = 0;
            while (cfg_valid !== 1'b1 && t < 200) begin
                @(posedge core_clk);
                t++;
            end
            // Word never arrived: count it as a mismatch
            if (t >= 200) begin
                failures++;
                $display("wrong value at %0t: no word from the FIFO", $time);
            end
            check(cfg_word, exp_q.pop_front());
            cfg_ready <= 1'b1;
            @(posedge core_clk);
            cfg_ready <= 1'b0;
            @(posedge core_clk);
        end
    endtask
    // Hang guard
    initial begin
        #400000;
        failures++;
        close_out();
    end
    // Main sequence
    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        cfg_ready = 1'b0;
        lsb_m = 1'b0;
        mem = '{default: 0};
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        void'($urandom(84962));
        repeat (8) @(posedge core_clk);
        check(23'({sdio_oe, cfg_valid, cfg_overrun, aux_func_en}), 23'h1);
        wr(1, 3, 8'($urandom));
        drain();
        rd(1, 3, 1'b1);
        rd(20, 1, 1'b0);
        acsp_host_i.idle_clocks(16);
        check(23'({sdio_oe, aux_func_en}), 23'h1);
        rd(1, 1, 1'b0);
        wr(0, 1, 8'h40);
        drain();
        wr(4, 2, 8'hC3);
        drain();
        rd(0, 6, 1'b0);
        wr(8, 5, 8'h5A);
        void'(exp_q.pop_back());
        check(23'(cfg_overrun), 23'h1);
        drain();
        rd(8, 5, 1'b0);
        // soft reset last
        // Host may not write again within the recovery time, so only reads follow
        wr(0, 1, 8'h81);
        drain();
        #20000;
        rd(0, 6, 1'b0);
        close_out();
    end
endmodule
